//--- verilog/sec_pkg.sv
package sec_pkg;
    // ------------------------------------------------------------
    // geometry
    // ------------------------------------------------------------
    localparam int DATA_W = 32;
    localparam int CHK_W = 8;
    localparam int ADDR_W = 6;
    localparam int DEPTH = 64;
    localparam int CNT_W = 16;
    localparam logic [CNT_W-1:0] CNT_RESET = 16'h0000;
    localparam logic [CHK_W-1:0] CHK_RESET = 8'h00;
    localparam logic [DATA_W-1:0] DATA_RESET = 32'h0000_0000;
    localparam logic [ADDR_W-1:0] ADDR_RESET = 6'h00;

    // request from the requester
    typedef struct packed {
        logic valid;
        logic write;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } sec_req_type;

    // answer to the requester
    typedef struct packed {
        logic valid;
        logic [DATA_W-1:0] rdata;
    } sec_rsp_type;

    // error capture, readable by software
    typedef struct packed {
        logic [CNT_W-1:0] single_count;
        logic [CNT_W-1:0] double_count;
        logic [ADDR_W-1:0] last_addr;
        logic [DATA_W-1:0] last_data;
        logic [CHK_W-1:0] last_syndrome;
    } sec_stat_type;
endpackage

//--- verilog/sec_checker.sv
module sec_checker (
    input wire logic clock,
    input wire logic srst,
    input wire logic enable,
    input wire logic clear,
    input wire sec_pkg::sec_req_type req,
    output sec_pkg::sec_rsp_type rsp,
    output logic irq_single,
    output logic irq_double,
    output logic bus_err_single,
    output logic bus_err_double,
    output sec_pkg::sec_stat_type stat
);
    // ------------------------------------------------------------
    // code functions
    // ------------------------------------------------------------
    // hamming(38,32) position map: data bit i sits at the i-th non power of two
    function automatic logic [5:0] data_pos(input int i);
        int p;
        int k;
        p = 0;
        k = 0;
        for (int n = 1; n < 40; n++) begin
            if ((n & (n - 1)) != 0) begin
                if (k == i) begin
                    p = n;
                end
                k++;
            end
        end
        return 6'(p);
    endfunction

    // six hamming bits plus overall parity over data and hamming bits
    function automatic logic [sec_pkg::CHK_W-1:0] encode(input logic [sec_pkg::DATA_W-1:0] d);
        logic [6:0] h;
        logic [5:0] pos;
        h = 7'h00;
        pos = 6'h00;
        for (int i = 0; i < sec_pkg::DATA_W; i++) begin
            pos = data_pos(i);
            if (d[i]) begin
                h[5:0] = h[5:0] ^ pos;
            end
        end
        h[6] = ^{d, h[5:0]};
        return {h[6], 1'b0, h[5:0]}; // bit 6 is always zero
    endfunction

    // ------------------------------------------------------------
    // storage, one data array and one check array per checker instance
    // ------------------------------------------------------------
    logic [sec_pkg::DATA_W-1:0] mem_data [sec_pkg::DEPTH];
    logic [sec_pkg::CHK_W-1:0] mem_chk [sec_pkg::DEPTH];
    logic [sec_pkg::DATA_W-1:0] next_mem_data [sec_pkg::DEPTH];
    logic [sec_pkg::CHK_W-1:0] next_mem_chk [sec_pkg::DEPTH];

    // write path
    always_comb begin
        next_mem_data = mem_data;
        next_mem_chk = mem_chk;
        if (req.valid && req.write) begin
            next_mem_data[req.addr] = req.wdata;
            if (enable) begin
                next_mem_chk[req.addr] = encode(req.wdata);
            end // else old check bits stay
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            for (int i = 0; i < sec_pkg::DEPTH; i++) begin
                mem_data[i] <= sec_pkg::DATA_RESET;
                mem_chk[i] <= sec_pkg::CHK_RESET;
            end
        end else begin
            mem_data <= next_mem_data;
            mem_chk <= next_mem_chk;
        end
    end

    // ------------------------------------------------------------
    // read check
    // ------------------------------------------------------------
    logic [sec_pkg::DATA_W-1:0] rd_raw;
    logic [sec_pkg::CHK_W-1:0] syndrome;
    logic [sec_pkg::CHK_W-1:0] chk_diff;
    logic [sec_pkg::DATA_W-1:0] rd_fixed;
    logic rd_go;
    logic err_single;
    logic err_double;

    // syndrome and classification
    always_comb begin
        rd_raw = mem_data[req.addr];
        rd_go = req.valid && !req.write;
        chk_diff = encode(rd_raw) ^ mem_chk[req.addr];
        // top bit becomes parity over the whole stored word; recomputed hamming
        // bits cancel, so any single flip sets it and any double flip clears it
        syndrome = {chk_diff[7] ^ (^chk_diff[5:0]), chk_diff[6:0]};
        err_single = rd_go && enable && syndrome[7];
        err_double = rd_go && enable && !syndrome[7] && (syndrome[5:0] != 6'h00);
        rd_fixed = rd_raw;
        for (int i = 0; i < sec_pkg::DATA_W; i++) begin
            if (err_single && syndrome[5:0] == data_pos(i)) begin
                rd_fixed[i] = ~rd_raw[i];
            end
        end
    end

    // ------------------------------------------------------------
    // answer, events, counters, capture
    // ------------------------------------------------------------
    sec_pkg::sec_rsp_type next_rsp;
    sec_pkg::sec_stat_type next_stat;
    logic next_single;
    logic next_double;

    always_comb begin
        next_rsp.valid = rd_go;
        next_rsp.rdata = rd_go ? rd_fixed : rsp.rdata; // double left as read
        next_single = err_single;
        next_double = err_double;
        next_stat = stat;
        if (clear) begin
            next_stat.single_count = sec_pkg::CNT_RESET;
            next_stat.double_count = sec_pkg::CNT_RESET;
            next_stat.last_addr = sec_pkg::ADDR_RESET;
            next_stat.last_data = sec_pkg::DATA_RESET;
            next_stat.last_syndrome = sec_pkg::CHK_RESET;
        end
        // an error in the clear cycle counts from zero, and its capture wins over the clear
        if (err_single) begin
            next_stat.single_count = (clear ? sec_pkg::CNT_RESET : stat.single_count)
                + 16'h0001;
        end
        if (err_double) begin
            next_stat.double_count = (clear ? sec_pkg::CNT_RESET : stat.double_count)
                + 16'h0001;
        end
        if (err_single || err_double) begin
            next_stat.last_addr = req.addr;
            next_stat.last_data = rd_raw;
            next_stat.last_syndrome = syndrome;
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            rsp <= '0;
            irq_single <= 1'b0;
            irq_double <= 1'b0;
            stat <= '0;
        end else begin
            rsp <= next_rsp;
            irq_single <= next_single;
            irq_double <= next_double;
            stat <= next_stat;
        end
    end

    // fabric error bus mirrors the interrupts
    assign bus_err_single = irq_single;
    assign bus_err_double = irq_double;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (srst);

    sequence s_single;
        err_single;
    endsequence

    sequence s_double;
        err_double;
    endsequence

    read_answer_a: assert property (rd_go |=> rsp.valid)
        else $error("read not answered next cycle");
    single_irq_a: assert property (s_single |=> irq_single && bus_err_single)
        else $error("single error not signalled");
    double_irq_a: assert property (s_double |=> irq_double && !irq_single)
        else $error("double error not signalled");
    single_count_a: assert property (err_single && !clear
        |=> stat.single_count == $past(stat.single_count) + 16'h0001)
        else $error("single counter not bumped");
    double_count_a: assert property (err_double && !clear
        |=> stat.double_count == $past(stat.double_count) + 16'h0001)
        else $error("double counter not bumped");
    clear_counts_a: assert property (clear && !rd_go
        |=> stat.single_count == 16'h0000 && stat.double_count == 16'h0000)
        else $error("clear did not reset counters");
    err_addr_a: assert property ((err_single || err_double)
        |=> stat.last_addr == $past(req.addr))
        else $error("error address not captured");
    syndrome_cap_a: assert property ((err_single || err_double)
        |=> stat.last_syndrome == $past(syndrome))
        else $error("syndrome not captured");
    // only a syndrome that points into the data field flips a data bit
    fixed_data_a: assert property (s_single && $countones(syndrome[5:0]) > 1
        && syndrome[5:0] < 6'h27
        |=> $countones(rsp.rdata ^ $past(rd_raw)) == 1)
        else $error("single error not corrected");
    disabled_quiet_a: assert property (!enable && !clear
        |=> !irq_single && !irq_double
        && $stable(stat.single_count) && $stable(stat.double_count))
        else $error("error flagged while disabled");
    double_raw_a: assert property (s_double
        |=> rsp.rdata == $past(rd_raw) && bus_err_double)
        else $error("double error data altered");
    err_data_a: assert property ((err_single || err_double)
        |=> stat.last_data == $past(rd_raw))
        else $error("error data not captured");
    idle_quiet_a: assert property (!rd_go |=> !rsp.valid && !irq_single && !irq_double)
        else $error("answer or interrupt without a read");
endmodule // sec_checker

//--- verif/sec_master.sv
// ----------------------------------------
// requester model
// ----------------------------------------
module sec_master (
    input wire logic clock,
    output sec_pkg::sec_req_type req
);
    timeunit 1ns;
    timeprecision 1ps;
    initial req = '0;
    // one request, held for one taking edge, then released with scrambled fields
    task automatic access(input logic wr, input logic [5:0] a, input logic [31:0] d);
        @(negedge clock);
        req <= {1'b1, wr, a, d};
        @(negedge clock);
        req <= {1'b0, ~wr, ~a, ~d};
    endtask
endmodule // sec_master

//--- verif/sec_checker_tb.sv
// ----------------------------------------
// bench top
// ----------------------------------------
module sec_checker_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock = 1'b0;
    logic srst = 1'b1;
    logic enable = 1'b0;
    logic clear = 1'b0;
    sec_pkg::sec_req_type req;
    sec_pkg::sec_rsp_type rsp;
    logic irq_single, irq_double, bus_err_single, bus_err_double;
    sec_pkg::sec_stat_type stat;
    int fails = 0;
    int n_tests = 0;
    int cycles = 0;
    always #5 clock = ~clock;
    sec_master m (.clock(clock), .req(req));
    sec_checker dut (.clock(clock), .srst(srst), .enable(enable), .clear(clear), .req(req),
        .rsp(rsp), .irq_single(irq_single), .irq_double(irq_double),
        .bus_err_single(bus_err_single), .bus_err_double(bus_err_double), .stat(stat));
    // compare and count
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fails++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // read one word and judge data and both flag classes
    task automatic read_expect(input logic [5:0] a, input logic [31:0] d, input logic s,
        input logic w);
        m.access(1'b0, a, 32'h0000_0000);
        chk(rsp.valid, 1'b1);
        chk(rsp.rdata, d);
        chk(irq_single, s);
        chk(irq_double, w);
        chk(bus_err_single, s);
        chk(bus_err_double, w);
    endtask
    // store a good word, then overwrite it with checking off
    task automatic plant(input logic [5:0] a, input logic [31:0] good, input logic [31:0] bad);
        enable = 1'b1;
        m.access(1'b1, a, good);
        enable = 1'b0;
        m.access(1'b1, a, bad);
        enable = 1'b1;
    endtask
    task automatic test_clean();
        enable = 1'b1;
        m.access(1'b1, 6'h3F, 32'hA5A5_5A5A);
        read_expect(6'h3F, 32'hA5A5_5A5A, 1'b0, 1'b0);
        m.access(1'b1, 6'h00, 32'hFFFF_FFFF);
        read_expect(6'h00, 32'hFFFF_FFFF, 1'b0, 1'b0);
        $display("clean done");
    endtask
    task automatic test_single();
        plant(6'h2A, 32'h1234_5678, 32'h1234_5778);
        read_expect(6'h2A, 32'h1234_5678, 1'b1, 1'b0);
        chk(stat.single_count, 16'h0001);
        chk(stat.double_count, 16'h0000);
        chk(stat.last_addr, 6'h2A);
        chk(stat.last_data, 32'h1234_5778);
        chk(stat.last_syndrome[7], 1'b1);
        $display("single done");
    endtask
    task automatic test_double();
        plant(6'h05, 32'hCAFE_0001, 32'h4AFE_0003);
        read_expect(6'h05, 32'h4AFE_0003, 1'b0, 1'b1);
        chk(stat.double_count, 16'h0001);
        chk(stat.last_addr, 6'h05);
        chk(stat.last_syndrome[7], 1'b0);
        chk(stat.last_syndrome[5:0] != 6'h00, 1'b1);
        $display("double done");
    endtask
    task automatic test_disabled_clear();
        enable = 1'b0;
        read_expect(6'h2A, 32'h1234_5778, 1'b0, 1'b0);
        chk(stat.single_count, 16'h0001);
        clear = 1'b1;
        @(negedge clock);
        clear = 1'b0;
        chk(stat.single_count, 16'h0000);
        chk(stat.double_count, 16'h0000);
        chk(stat.last_addr, 6'h00);
        enable = 1'b1;
        read_expect(6'h2A, 32'h1234_5678, 1'b1, 1'b0);
        chk(stat.single_count, 16'h0001);
        $display("disabled and clear done");
    endtask
    // cycle ceiling against hangs
    always @(posedge clock) begin
        cycles++;
        if (cycles == 2000) begin
            fails++;
            complete_run();
        end
    end
    initial begin
        repeat (8) @(negedge clock);
        srst = 1'b0;
        test_clean();
        test_single();
        test_double();
        test_disabled_clear();
        complete_run();
    end
endmodule // sec_checker_tb
